/* File: shared/scsb_pkg.sv */
// scsb_pkg: register map, field positions and reset values of the
// system-control register bank.
// assumes: register index times four is the byte address on APB.
package scsb_pkg;

  ////////////////////////////////////////////////////////////////////
  // register indices (byte address = index * 4)
  localparam logic [5:0] OFS_PROCESSOR_MODE_0 = 6'h04;
  localparam logic [5:0] OFS_PROCESSOR_MODE_1 = 6'h05;
  localparam logic [5:0] OFS_SYSTEM_CLOCK_CONTROL_0 = 6'h06;
  localparam logic [5:0] OFS_SYSTEM_CLOCK_CONTROL_1 = 6'h07;
  localparam logic [5:0] OFS_CHIP_SELECT_CONTROL = 6'h08;
  localparam logic [5:0] OFS_ADDR_MATCH_IRQ_ENABLE = 6'h09;
  localparam logic [5:0] OFS_WRITE_PROTECT = 6'h0A;
  localparam logic [5:0] OFS_DATA_BANK = 6'h0B;
  localparam logic [5:0] OFS_OSC_STOP_DETECT = 6'h0C;
  localparam logic [5:0] OFS_WATCHDOG_START = 6'h0E;
  localparam logic [5:0] OFS_WATCHDOG_CONTROL = 6'h0F;
  localparam logic [5:0] OFS_ADDR_MATCH_0 = 6'h10;
  localparam logic [5:0] OFS_ADDR_MATCH_1 = 6'h14;
  localparam logic [5:0] OFS_VOLTAGE_DETECT_1 = 6'h19;
  localparam logic [5:0] OFS_VOLTAGE_DETECT_2 = 6'h1A;
  localparam logic [5:0] OFS_CHIP_SELECT_EXPANSION = 6'h1B;
  localparam logic [5:0] OFS_PLL_CONTROL_0 = 6'h1C;
  localparam logic [5:0] OFS_PROCESSOR_MODE_2 = 6'h1E;
  localparam logic [5:0] OFS_LOW_VOLTAGE_IRQ = 6'h1F;
  localparam logic [5:0] OFS_DMA_CH0_SOURCE = 6'h20;
  localparam logic [5:0] OFS_DMA_CH0_DEST = 6'h24;
  localparam logic [5:0] OFS_DMA_CH0_COUNT = 6'h28;
  localparam logic [5:0] OFS_DMA_CH0_CONTROL = 6'h2C;
  localparam logic [5:0] OFS_DMA_CH1_SOURCE = 6'h30;
  localparam logic [5:0] OFS_DMA_CH1_DEST = 6'h34;
  localparam logic [5:0] OFS_DMA_CH1_COUNT = 6'h38;
  localparam logic [5:0] OFS_DMA_CH1_CONTROL = 6'h3C;

  localparam int NUM_REGS = 27;
  localparam int REG_W = 24;

  // entry numbers of registers with special behaviour
  localparam int ENT_PROCESSOR_MODE_0 = 0;
  localparam int ENT_OSC_STOP_DETECT = 8;
  localparam int ENT_WATCHDOG_CONTROL = 10;

  ////////////////////////////////////////////////////////////////////
  // field positions
  localparam int POS_PROC_MODE_SELECT_LO = 0;
  localparam int POS_PROC_MODE_SELECT_HI = 1;
  localparam int POS_OSC_STOP_DETECT_ENABLE = 0;
  localparam int POS_OSC_STOP_CLOCK_SWITCH = 1;
  localparam int POS_OSC_STOP_RESET_OR_IRQ = 7;
  localparam int POS_COLD_START_FLAG = 5;
  localparam int POS_CS0_ENABLE = 0;

  ////////////////////////////////////////////////////////////////////
  // per-entry tables, entry order as above
  localparam logic [5:0] REG_INDEX [NUM_REGS] = '{
    OFS_PROCESSOR_MODE_0, OFS_PROCESSOR_MODE_1, OFS_SYSTEM_CLOCK_CONTROL_0,
    OFS_SYSTEM_CLOCK_CONTROL_1, OFS_CHIP_SELECT_CONTROL, OFS_ADDR_MATCH_IRQ_ENABLE,
    OFS_WRITE_PROTECT, OFS_DATA_BANK, OFS_OSC_STOP_DETECT, OFS_WATCHDOG_START,
    OFS_WATCHDOG_CONTROL, OFS_ADDR_MATCH_0, OFS_ADDR_MATCH_1, OFS_VOLTAGE_DETECT_1,
    OFS_VOLTAGE_DETECT_2, OFS_CHIP_SELECT_EXPANSION, OFS_PLL_CONTROL_0,
    OFS_PROCESSOR_MODE_2, OFS_LOW_VOLTAGE_IRQ, OFS_DMA_CH0_SOURCE, OFS_DMA_CH0_DEST,
    OFS_DMA_CH0_COUNT, OFS_DMA_CH0_CONTROL, OFS_DMA_CH1_SOURCE, OFS_DMA_CH1_DEST,
    OFS_DMA_CH1_COUNT, OFS_DMA_CH1_CONTROL};

  // implemented bits; everything else has no storage and reads zero
  localparam logic [23:0] REG_MASK [NUM_REGS] = '{
    24'h0000FF, 24'h0000FF, 24'h0000FF, 24'h0000FF, 24'h0000FF, 24'h000003,
    24'h0000FF, 24'h0000FF, 24'h0000BF, 24'h0000FF, 24'h0000A0, 24'h0FFFFF,
    24'h0FFFFF, 24'h0000FF, 24'h0000FF, 24'h0000FF, 24'h0000F7, 24'h00001F,
    24'h0000FF, 24'hFFFFFF, 24'hFFFFFF, 24'h00FFFF, 24'h0000FB, 24'hFFFFFF,
    24'hFFFFFF, 24'h00FFFF, 24'h0000FB};

  // reset values; undefined contents come up as zero
  localparam logic [23:0] REG_RESET [NUM_REGS] = '{
    24'h000000, 24'h000008, 24'h000048, 24'h000020, 24'h000001, 24'h000000,
    24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000,
    24'h000000, 24'h000008, 24'h000000, 24'h000000, 24'h000012, 24'h000000,
    24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000,
    24'h000000, 24'h000000, 24'h000000};

  // bits kept through software, watchdog and osc-stop resets
  localparam logic [23:0] KEEP_SOFT [NUM_REGS] = '{
    24'h000003, 24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000,
    24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000020, 24'h000000,
    24'h000000, 24'h0000FF, 24'h0000FF, 24'h000000, 24'h000000, 24'h000000,
    24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000,
    24'h000000, 24'h000000, 24'h000000};

  // bits additionally kept only through an osc-stop reset
  localparam logic [23:0] KEEP_OSC_STOP = 24'h000083;

  // bits that a write can only set, never clear
  localparam logic [23:0] SET_ONLY_WDC = 24'h000020;

endpackage : scsb_pkg

/* File: core/scsb_reg_bank.sv */
// scsb_reg_bank: system-control register bank behind an APB slave.
// assumes: APB master on clk; soft reset requests are one-cycle,
// synchronous pulses from the reset controller; boot pin is stable.
//
// How it works
// - mode register 0 comes up with mode bits set when boot pin is high
// - mode select bits survive software, watchdog and osc-stop resets
// - osc-stop detect enable, switch and select bits survive osc-stop reset
// - cold-start flag is zero at power-on and only a write sets it
// - both voltage-detect registers survive software, watchdog, osc-stop resets
// - undefined bit positions have no storage behind them
// - clock control register 0 resets to 0x48
// - clock control register 1 resets to 0x20
// - processor mode register 1 resets to 0x08
// - chip select control resets with only chip select 0 enabled
// - DMA control resets to zero with bit 2 unmapped
// - PLL control resets to 0x12 with bit 3 unmapped
// - osc-stop register resets to zero with bit 6 unmapped
// - address-match enable holds two bits, both cleared at reset
// - address-match registers hold 20 bits, cleared at reset
// - processor mode register 2 holds five bits, cleared at reset
`timescale 1ns/1ps

module scsb_reg_bank #(
  parameter int ADDR_WIDTH = 8
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // reset requests and strap
  input wire logic swResetReq,
  input wire logic wdtResetReq,
  input wire logic oscStopResetReq,
  input wire logic bootSelectPin,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // control taps
  output logic [1:0] procModeSelect,
  output logic oscStopDetectEnable,
  output logic oscStopResetOrIrq,
  output logic coldStartFlag,
  output logic chipSelect0Enable
);

  ////////////////////////////////////////////////////////////////////
  // elaboration check: the map needs eight address bits
  if (ADDR_WIDTH < 8) begin : gBadWidth
    $error("scsb_reg_bank: ADDR_WIDTH below 8 cannot reach the map");
  end

  ////////////////////////////////////////////////////////////////////
  // storage
  logic [23:0] regQ [scsb_pkg::NUM_REGS];
  logic [scsb_pkg::NUM_REGS-1:0] hitVec;
  logic strapDone_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;

  ////////////////////////////////////////////////////////////////////
  // bus decode
  // upper bits beyond the map and byte offsets inside a word miss
  wire upperZero = (paddr >> 8) == '0;
  wire wordAligned = (paddr[1:0] == 2'h0);
  wire [5:0] wordIdx = paddr[7:2];
  wire addrOk = upperZero && wordAligned;
  wire setupPhase = psel && !penable;
  wire accessDone = psel && penable && pready_reg;
  wire wrStrobe = accessDone && pwrite && clkEn;
  wire softRst = swResetReq || wdtResetReq || oscStopResetReq;
  wire strapNow = !strapDone_reg && clkEn;

  ////////////////////////////////////////////////////////////////////
  // one entry per register
  for (genvar gi = 0; gi < scsb_pkg::NUM_REGS; gi++) begin : gEntry
    localparam logic [23:0] MASK = scsb_pkg::REG_MASK[gi];
    localparam logic [23:0] RST = scsb_pkg::REG_RESET[gi];
    localparam logic [23:0] KEEP_BASE = scsb_pkg::KEEP_SOFT[gi];
    localparam logic [23:0] KEEP_OSC =
      (gi == scsb_pkg::ENT_OSC_STOP_DETECT) ? scsb_pkg::KEEP_OSC_STOP : 24'h000000;
    localparam logic [23:0] SET_ONLY =
      (gi == scsb_pkg::ENT_WATCHDOG_CONTROL) ? scsb_pkg::SET_ONLY_WDC : 24'h000000;

    logic [23:0] next;

    // reserved gaps never match, so writes there land nowhere
    assign hitVec[gi] = addrOk && (wordIdx == scsb_pkg::REG_INDEX[gi]);

    // a set-only bit ors the new data onto the old, so zero never clears it
    wire [23:0] wrVal = ((pwdata[23:0] & ~SET_ONLY) | ((pwdata[23:0] | regQ[gi]) & SET_ONLY))
      & MASK;
    // osc-stop reset additionally protects its own detect bits
    wire [23:0] keep = KEEP_BASE | (oscStopResetReq ? KEEP_OSC : 24'h000000);
    wire [23:0] softVal = ((regQ[gi] & keep) | (RST & ~keep)) & MASK;
    wire [23:0] baseNext = softRst ? softVal : ((wrStrobe && hitVec[gi]) ? wrVal : regQ[gi]);

    if (gi == scsb_pkg::ENT_PROCESSOR_MODE_0) begin : gStrap
      // the strap is caught on the first enabled edge after release,
      // since an async reset may only load constants
      always_comb begin
        next = baseNext;
        if (strapNow) begin
          next[scsb_pkg::POS_PROC_MODE_SELECT_LO] = bootSelectPin;
          next[scsb_pkg::POS_PROC_MODE_SELECT_HI] = bootSelectPin;
        end
      end
    end else begin : gPlain
      always_comb begin
        next = baseNext;
      end
    end

    // reset values through the package tables
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        regQ[gi] <= RST & MASK;
      end else if (clkEn) begin
        regQ[gi] <= next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // strap capture tracker
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strapDone_reg <= 1'b0;
    end else if (clkEn) begin
      strapDone_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux: a miss returns zero and the high byte is always zero
  always_comb begin
    prdata_next = 32'h00000000;
    for (int i = 0; i < scsb_pkg::NUM_REGS; i++) begin
      if (hitVec[i]) begin
        prdata_next = prdata_next | {8'h00, regQ[i]};
      end
    end
  end

  // no wait state: data is registered in setup, valid in the first access cycle
  assign pready_next = setupPhase;

  ////////////////////////////////////////////////////////////////////
  // apb answer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
    end else if (clkEn) begin
      pready_reg <= pready_next;
      if (setupPhase) begin
        prdata_reg <= prdata_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs, straight from flops apart from the constant pslverr
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = 1'b0; // reserved addresses answer quietly, no error
  assign procModeSelect =
    regQ[scsb_pkg::ENT_PROCESSOR_MODE_0][scsb_pkg::POS_PROC_MODE_SELECT_HI:0];
  assign oscStopDetectEnable =
    regQ[scsb_pkg::ENT_OSC_STOP_DETECT][scsb_pkg::POS_OSC_STOP_DETECT_ENABLE];
  assign oscStopResetOrIrq =
    regQ[scsb_pkg::ENT_OSC_STOP_DETECT][scsb_pkg::POS_OSC_STOP_RESET_OR_IRQ];
  assign coldStartFlag =
    regQ[scsb_pkg::ENT_WATCHDOG_CONTROL][scsb_pkg::POS_COLD_START_FLAG];
  assign chipSelect0Enable = regQ[4][scsb_pkg::POS_CS0_ENABLE];

endmodule : scsb_reg_bank

/* File: verif/scsb_reg_bank_props.sv */
// scsb_reg_bank_props: port-level checks of the register bank.
// assumes: bound to every scsb_reg_bank instance, single clock domain.
`timescale 1ns/1ps
module scsb_reg_bank_props #(
  parameter int ADDR_WIDTH = 8
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // reset requests and strap
  input wire logic swResetReq,
  input wire logic wdtResetReq,
  input wire logic oscStopResetReq,
  input wire logic bootSelectPin,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // control taps
  input wire logic [1:0] procModeSelect,
  input wire logic oscStopDetectEnable,
  input wire logic oscStopResetOrIrq,
  input wire logic coldStartFlag,
  input wire logic chipSelect0Enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // any soft reset that the bank will act on
  wire logic softRst = (swResetReq | wdtResetReq | oscStopResetReq) & clkEn;
  wire logic wdcSet = psel & penable & pwrite & pready & pwdata[5]
    & (paddr == ADDR_WIDTH'(8'h3C));
  ////////////////////////////////////////////////////////////////////
  no_error_a: assert property (pslverr == 1'b0)
    else $error("slave error raised");
  top_zero_a: assert property (prdata[31:24] == 8'h00)
    else $error("unmapped read bits set");
  ready_pulse_a: assert property (pready && clkEn |=> !pready)
    else $error("ready held too long");
  mode_keep_a: assert property (softRst |=> $stable(procModeSelect))
    else $error("mode bits lost on soft reset");
  cold_keep_a: assert property (coldStartFlag |=> coldStartFlag)
    else $error("cold flag cleared");
  cold_set_a: assert property ($rose(coldStartFlag) |-> $past(wdcSet))
    else $error("cold flag set without write");
  osc_keep_a:
    assert property (oscStopResetReq && clkEn |=>
      $stable({oscStopDetectEnable, oscStopResetOrIrq}))
    else $error("osc bits lost on osc reset");
  osc_clear_a:
    assert property ((swResetReq || wdtResetReq) && !oscStopResetReq && clkEn |=>
      !oscStopDetectEnable && !oscStopResetOrIrq)
    else $error("osc bits not cleared");
  cs_default_a: assert property (softRst |=> chipSelect0Enable)
    else $error("chip select 0 not enabled");
  soft_cov: cover property (softRst);
  cold_cov: cover property ($rose(coldStartFlag));
  read_cov: cover property (pready && !pwrite);
endmodule : scsb_reg_bank_props

bind scsb_reg_bank scsb_reg_bank_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (.clk(clk),
  .rst_n(rst_n), .clkEn(clkEn), .swResetReq(swResetReq), .wdtResetReq(wdtResetReq),
  .oscStopResetReq(oscStopResetReq), .bootSelectPin(bootSelectPin), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .procModeSelect(procModeSelect),
  .oscStopDetectEnable(oscStopDetectEnable), .oscStopResetOrIrq(oscStopResetOrIrq),
  .coldStartFlag(coldStartFlag), .chipSelect0Enable(chipSelect0Enable));

/* File: verif/tb.sv */
// tb: self-checking bench for the register bank over APB.
// assumes: scsb_pkg compiled first; checker bound from its own file.
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, clkEn, swResetReq, wdtResetReq, oscStopResetReq, bootSelectPin;
  logic psel, penable, pwrite, pready, pslverr, chipSelect0Enable;
  logic oscStopDetectEnable, oscStopResetOrIrq, coldStartFlag;
  logic [1:0] procModeSelect;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [23:0] mirror [scsb_pkg::NUM_REGS];
  logic [7:0] bad [7] = '{8'h00, 8'h0C, 8'h34, 8'h60, 8'h74, 8'h11, 8'hFC};
  logic [15:0] seed = 16'h001E;
  int fails = 0;
  int testsRun = 0;
  scsb_reg_bank #(.ADDR_WIDTH(8)) u_dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .swResetReq(swResetReq), .wdtResetReq(wdtResetReq), .oscStopResetReq(oscStopResetReq),
    .bootSelectPin(bootSelectPin), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .procModeSelect(procModeSelect), .oscStopDetectEnable(oscStopDetectEnable),
    .oscStopResetOrIrq(oscStopResetOrIrq), .coldStartFlag(coldStartFlag),
    .chipSelect0Enable(chipSelect0Enable));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////
  // lfsr source of random values
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  // expected contents after a write; cold flag can only be set
  function automatic logic [23:0] wr_exp(int i, logic [23:0] d);
    logic [23:0] s;
    s = (i == scsb_pkg::ENT_WATCHDOG_CONTROL) ? mirror[i] & scsb_pkg::SET_ONLY_WDC : 24'h0;
    return (d & scsb_pkg::REG_MASK[i]) | s;
  endfunction
  // expected contents after a soft reset
  function automatic logic [23:0] soft_exp(int i, logic osc);
    logic [23:0] k;
    k = scsb_pkg::KEEP_SOFT[i];
    if (osc && i == scsb_pkg::ENT_OSC_STOP_DETECT) k = k | scsb_pkg::KEEP_OSC_STOP;
    return (mirror[i] & k) | (scsb_pkg::REG_RESET[i] & ~k);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; ready and read data are taken at the rising edge
  // that completes the access, and only then is the request released
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      fails++;
      $display("Error %0t: no ready from the bank", $time);
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(int i, logic [31:0] d);
    apb({scsb_pkg::REG_INDEX[i], 2'b00}, 1'b1, d);
    mirror[i] = wr_exp(i, d[23:0]);
  endtask
  task automatic scan();
    for (int i = 0; i < scsb_pkg::NUM_REGS; i++) begin
      apb({scsb_pkg::REG_INDEX[i], 2'b00}, 1'b0, 32'h0);
      chk(q, {8'h00, mirror[i]});
    end
    chk({26'h0, procModeSelect, coldStartFlag, oscStopDetectEnable, oscStopResetOrIrq,
      chipSelect0Enable}, {26'h0, mirror[0][1:0], mirror[10][5], mirror[8][0],
      mirror[8][7], mirror[4][0]});
  endtask
  task automatic por();
    rst_n <= 1'b0;
    bootSelectPin <= seed[3];
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < scsb_pkg::NUM_REGS; i++) mirror[i] = scsb_pkg::REG_RESET[i];
    mirror[0][1:0] = {2{bootSelectPin}};
    chk({31'h0, coldStartFlag}, 32'h0);
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {clkEn, swResetReq, wdtResetReq, oscStopResetReq, psel, penable, pwrite} = 7'h40;
    {paddr, pwdata} = '0;
    por();
    scan();
    $display("test reset values finished");
    wr(scsb_pkg::ENT_WATCHDOG_CONTROL, 32'h00000020);
    wr(scsb_pkg::ENT_WATCHDOG_CONTROL, 32'h00000000);
    foreach (bad[k]) begin
      apb(bad[k], 1'b1, 32'hFFFFFFFF);
      apb(bad[k], 1'b0, 32'h0);
      chk(q, 32'h0);
    end
    scan();
    $display("test reserved and cold flag finished");
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < scsb_pkg::NUM_REGS; i++) wr(i, {rnd(), rnd()});
      @(posedge clk);
      clkEn <= 1'b0;
      swResetReq <= (k == 0);
      wdtResetReq <= (k == 1);
      oscStopResetReq <= (k == 2);
      repeat (2) @(posedge clk);
      clkEn <= 1'b1;
      @(posedge clk);
      {swResetReq, wdtResetReq, oscStopResetReq} <= 3'b000;
      for (int i = 0; i < scsb_pkg::NUM_REGS; i++) mirror[i] = soft_exp(i, k == 2);
      scan();
      $display("test soft reset %0d finished", k);
    end
    por();
    scan();
    $display("test second power-on finished");
    report_and_stop();
  end
  // hang guard, far above the roughly 800 cycles the run needs
  initial begin
    #500000;
    fails++;
    report_and_stop();
  end
endmodule : tb
